// file: timer_defs.svh
// Register indices, field positions, reset values and counts of the timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define IDX_PIN_CFG    6'h10
`define IDX_CONTROL    6'h12
`define IDX_STATUS     6'h13
`define IDX_CAP_HIGH   6'h14
`define IDX_CAP_LOW    6'h15
`define IDX_CMP_HIGH   6'h16
`define IDX_CMP_LOW    6'h17
`define IDX_CNT_HIGH   6'h18
`define IDX_CNT_LOW    6'h19
`define IDX_VIEWB_HIGH 6'h1a
`define IDX_VIEWB_LOW  6'h1b

`define PIN_RUN_BIT    0
`define CTL_CAP_IE_BIT 7
`define CTL_CMP_IE_BIT 6
`define CTL_OVF_IE_BIT 5
`define CTL_EDGE_BIT   1
`define CTL_LEVEL_BIT  0
`define STAT_CAP_BIT   7
`define STAT_CMP_BIT   6
`define STAT_OVF_BIT   5

`define CNT_RESET      16'hfffc
`define CNT_MAX        16'hffff
`define CTL_RESET      8'h00
`define PIN_CFG_RESET  8'h00
`define PRESCALE_LAST  2'h3
`define PRESCALE_CMP   2'h0
`define STARTUP_CYCLES 4096

`endif

// file: timer_pkg.sv
// Types shared by the timer design
package timer_pkg;

	typedef enum logic [1:0]
	{
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_type;

	typedef struct packed
	{
		logic capture;
		logic compare;
		logic overflow;
	} flags_type;

endpackage

// file: free_running_capture_compare_timer.sv
// Free-running 16-bit timer with capture, compare and overflow, Avalon-MM slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "timer_defs.svh"

module free_running_capture_compare_timer
	import timer_pkg::*;
#(
	parameter int unsigned STARTUP_CYCLES = `STARTUP_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Pins
	input  wire logic        capture_in_pin,
	output logic             compare_out_pin,
	output logic             compare_pin_en,
	// Timer interrupt request
	output logic             timer_irq
);

	localparam int SW = $clog2(STARTUP_CYCLES + 1);

	bus_state_type state_reg;
	logic [31:0]   readdata_reg;
	logic          waitrequest_reg;
	logic [7:0]    read_next;
	logic [7:0]    snap_low_reg;

	logic [7:0]    pin_cfg_reg;
	logic [7:0]    control_reg;
	flags_type     flags_reg;
	flags_type     arm_reg;
	logic [15:0]   cnt_reg;
	logic [1:0]    presc_reg;
	logic [SW-1:0] start_cnt_reg;
	logic          running_reg;
	logic [15:0]   cap_val_reg;
	logic [15:0]   cmp_val_reg;
	logic [7:0]    low_buf_reg;
	logic          low_buf_valid_reg;
	logic          cap_inhibit_reg;
	logic          cmp_inhibit_reg;
	logic          out_level_reg;
	logic          irq_reg;
	logic          sync1_reg;
	logic          sync2_reg;
	logic          prev_reg;

	logic [5:0]    idx;
	logic          accept;
	logic          rd_acc;
	logic          wr_acc;
	logic          tick;
	logic          cap_edge;
	logic          cap_evt;
	logic          cmp_evt;
	logic          ovf_evt;

	function automatic logic hit(input logic [7:0] addr, input logic [5:0] target);
		hit = (addr[7:2] == target) && (addr[1:0] == 2'b00);
	endfunction

	assign idx    = address[7:2];
	assign accept = (state_reg == BUS_ANSWER) && (read || write);
	assign rd_acc = accept && read;
	assign wr_acc = accept && write && byteenable[0];

	// Bus handshake: one wait cycle, access takes effect as waitrequest is seen low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg       <= BUS_IDLE;
			waitrequest_reg <= 1'b1;
			readdata_reg    <= 32'h0000_0000;
			snap_low_reg    <= 8'h00;
		end
		else
		begin
			case (state_reg)
				BUS_IDLE:
				begin
					if (read || write)
					begin
						state_reg       <= BUS_ANSWER;
						waitrequest_reg <= 1'b0;
						readdata_reg    <= {24'h00_0000, read_next};
						snap_low_reg    <= cnt_reg[7:0];
					end
				end
				BUS_ANSWER:
				begin
					state_reg       <= BUS_IDLE;
					waitrequest_reg <= 1'b1;
				end
				default:
				begin
					state_reg       <= BUS_IDLE;
					waitrequest_reg <= 1'b1;
				end
			endcase
		end
	end

	// Read mux; unmapped words read as zero
	always_comb
	begin
		read_next = 8'h00;
		if (address[1:0] == 2'b00)
		begin
			case (idx)
				`IDX_PIN_CFG: read_next = pin_cfg_reg;
				`IDX_CONTROL: read_next = control_reg;
				`IDX_STATUS:  read_next = {flags_reg, 5'b00000};
				`IDX_CAP_HIGH: read_next = cap_val_reg[15:8];
				`IDX_CAP_LOW: read_next = cap_val_reg[7:0];
				`IDX_CMP_HIGH: read_next = cmp_val_reg[15:8];
				`IDX_CMP_LOW: read_next = cmp_val_reg[7:0];
				`IDX_CNT_HIGH, `IDX_VIEWB_HIGH: read_next = cnt_reg[15:8];
				`IDX_CNT_LOW, `IDX_VIEWB_LOW:
					read_next = low_buf_valid_reg ? low_buf_reg : cnt_reg[7:0];
				default: read_next = 8'h00;
			endcase
		end
	end

	// Software-written configuration; the counter itself has no write path
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_cfg_reg <= `PIN_CFG_RESET;
			control_reg <= `CTL_RESET;
		end
		else if (wr_acc)
		begin
			if (hit(address, `IDX_PIN_CFG))
				pin_cfg_reg <= writedata[7:0];
			if (hit(address, `IDX_CONTROL))
				control_reg <= writedata[7:0];
		end
	end

	// Start-up delay, then prescaler and counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_cnt_reg <= '0;
			running_reg   <= 1'b0;
		end
		else if (!running_reg)
		begin
			if (start_cnt_reg == SW'(STARTUP_CYCLES - 1))
				running_reg <= 1'b1;
			else
				start_cnt_reg <= start_cnt_reg + SW'(1);
		end
	end

	assign tick    = running_reg && (presc_reg == `PRESCALE_LAST);
	assign ovf_evt = tick && (cnt_reg == `CNT_MAX);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			presc_reg <= 2'h0;
			cnt_reg   <= `CNT_RESET;
		end
		else if (running_reg)
		begin
			presc_reg <= presc_reg + 2'h1;
			if (tick)
				cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// Low byte coherency buffer shared by both counter views
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			low_buf_reg       <= 8'h00;
			low_buf_valid_reg <= 1'b0;
		end
		else if (rd_acc)
		begin
			if ((hit(address, `IDX_CNT_HIGH) || hit(address, `IDX_VIEWB_HIGH))
				&& !low_buf_valid_reg)
			begin
				low_buf_reg       <= snap_low_reg;
				low_buf_valid_reg <= 1'b1;
			end
			else if (hit(address, `IDX_CNT_LOW) || hit(address, `IDX_VIEWB_LOW))
				low_buf_valid_reg <= 1'b0;
		end
	end

	// Capture pin synchroniser and edge detect on the second stage only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end
		else
		begin
			sync1_reg <= capture_in_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign cap_edge = control_reg[`CTL_EDGE_BIT] ?
		(sync2_reg && !prev_reg) : (!sync2_reg && prev_reg);
	assign cap_evt  = cap_edge && !cap_inhibit_reg;

	// Capture register and its high-byte inhibit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_val_reg     <= 16'h0000;
			cap_inhibit_reg <= 1'b0;
		end
		else
		begin
			if (cap_evt)
				cap_val_reg <= cnt_reg;
			if (rd_acc && hit(address, `IDX_CAP_HIGH))
				cap_inhibit_reg <= 1'b1;
			else if (rd_acc && hit(address, `IDX_CAP_LOW))
				cap_inhibit_reg <= 1'b0;
		end
	end

	// Compare register; checked once per count value
	assign cmp_evt = running_reg && (presc_reg == `PRESCALE_CMP) && !cmp_inhibit_reg
		&& (cnt_reg == cmp_val_reg);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp_val_reg     <= 16'h0000;
			cmp_inhibit_reg <= 1'b0;
		end
		else if (wr_acc)
		begin
			if (hit(address, `IDX_CMP_HIGH))
			begin
				cmp_val_reg[15:8] <= writedata[7:0];
				cmp_inhibit_reg   <= 1'b1;
			end
			if (hit(address, `IDX_CMP_LOW))
			begin
				cmp_val_reg[7:0] <= writedata[7:0];
				cmp_inhibit_reg  <= 1'b0;
			end
		end
	end

	// Output level follows the level bit at each match, flag state regardless
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			out_level_reg <= 1'b0;
		else if (cmp_evt)
			out_level_reg <= control_reg[`CTL_LEVEL_BIT];
	end

	// Two-step flag clearing; a new event in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_reg <= '0;
			arm_reg   <= '0;
		end
		else
		begin
			if (rd_acc && hit(address, `IDX_STATUS) && flags_reg.capture)
				arm_reg.capture <= 1'b1;
			else if (rd_acc && hit(address, `IDX_CAP_LOW))
				arm_reg.capture <= 1'b0;
			if (cap_evt)
				flags_reg.capture <= 1'b1;
			else if (rd_acc && hit(address, `IDX_CAP_LOW) && arm_reg.capture)
				flags_reg.capture <= 1'b0;

			if (rd_acc && hit(address, `IDX_STATUS) && flags_reg.compare)
				arm_reg.compare <= 1'b1;
			else if (accept && hit(address, `IDX_CMP_LOW))
				arm_reg.compare <= 1'b0;
			if (cmp_evt)
				flags_reg.compare <= 1'b1;
			else if (accept && hit(address, `IDX_CMP_LOW) && arm_reg.compare)
				flags_reg.compare <= 1'b0;

			// Writes arm too; reading view B avoids an accidental clear
			if (accept && hit(address, `IDX_STATUS) && flags_reg.overflow)
				arm_reg.overflow <= 1'b1;
			else if (rd_acc && hit(address, `IDX_CNT_LOW))
				arm_reg.overflow <= 1'b0;
			if (ovf_evt)
				flags_reg.overflow <= 1'b1;
			else if (rd_acc && hit(address, `IDX_CNT_LOW) && arm_reg.overflow)
				flags_reg.overflow <= 1'b0;
		end
	end

	// Interrupt request gated by the three enables
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= (flags_reg.capture && control_reg[`CTL_CAP_IE_BIT])
				|| (flags_reg.compare && control_reg[`CTL_CMP_IE_BIT])
				|| (flags_reg.overflow && control_reg[`CTL_OVF_IE_BIT]);
	end

	assign readdata        = readdata_reg;
	assign waitrequest     = waitrequest_reg;
	assign compare_out_pin = out_level_reg;
	assign compare_pin_en  = pin_cfg_reg[`PIN_RUN_BIT];
	assign timer_irq       = irq_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_COUNT_STEP: assert property (tick |=> cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("Counter did not advance on prescaler tick");
	AST_COUNT_HOLD: assert property (!tick |=> $stable(cnt_reg))
		else $error("Counter moved between prescaler ticks");
	AST_START_PRESET: assert property (!running_reg |-> cnt_reg == `CNT_RESET)
		else $error("Counter left preset before start-up ended");
	AST_OVF_SET: assert property (ovf_evt |=> flags_reg.overflow && cnt_reg == 16'h0000)
		else $error("Overflow flag not set on wrap");
	AST_VIEWB_KEEPS: assert property (
		rd_acc && hit(address, `IDX_VIEWB_LOW) && flags_reg.overflow
		|=> flags_reg.overflow)
		else $error("View B low read cleared overflow");
	AST_IRQ_GATE: assert property (
		flags_reg.overflow && control_reg[`CTL_OVF_IE_BIT] |=> irq_reg)
		else $error("Enabled overflow raised no request");
	AST_IRQ_BLOCK: assert property (
		control_reg == 8'h00 ##1 control_reg == 8'h00 |-> !irq_reg)
		else $error("Request raised with all enables clear");
	AST_CAP_LATCH: assert property (cap_evt |=> cap_val_reg == $past(cnt_reg)
		&& flags_reg.capture)
		else $error("Capture did not latch counter");
	AST_CMP_LEVEL: assert property (cmp_evt |=> out_level_reg == $past(control_reg[0])
		&& flags_reg.compare)
		else $error("Compare did not clock level bit");
	AST_STATUS_LOW_ZERO: assert property (
		state_reg == BUS_ANSWER && hit(address, `IDX_STATUS) |-> readdata_reg[4:0] == 5'h00)
		else $error("Status low bits not zero");
	AST_BUF_FROZEN: assert property (
		low_buf_valid_reg && rd_acc && hit(address, `IDX_CNT_HIGH) |=> $stable(low_buf_reg))
		else $error("Low buffer changed on repeated high read");
	AST_WAIT_ONE: assert property (
		state_reg == BUS_IDLE && (read || write) |=> !waitrequest_reg ##1 waitrequest_reg)
		else $error("Bus answer not after exactly one wait cycle");
endmodule

// file: tb_free_running_capture_compare_timer.sv
// Self-checking bench for the free-running capture and compare timer
`timescale 1ns/1ps
`include "timer_defs.svh"

module tb_free_running_capture_compare_timer;
	logic        clk            = 1'b0;
	logic        rst_n          = 1'b0;
	logic [7:0]  address        = 8'h00;
	logic        read           = 1'b0;
	logic        write          = 1'b0;
	logic [31:0] writedata      = 32'h0;
	logic [3:0]  byteenable     = 4'h1;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        capture_in_pin = 1'b0;
	logic        compare_out_pin;
	logic        compare_pin_en;
	logic        timer_irq;
	logic [15:0] note_q[$];
	logic [15:0] note;
	logic [31:0] seed           = 32'he0fbb907;
	logic [7:0]  rd;
	logic [15:0] cnt;
	int          fails          = 0;
	int          comparisons    = 0;

	// Short start-up delay keeps the run brief
	free_running_capture_compare_timer #(.STARTUP_CYCLES(4)) i_free_running_capture_compare_timer
	(
		.clk             (clk),
		.rst_n           (rst_n),
		.address         (address),
		.read            (read),
		.write           (write),
		.writedata       (writedata),
		.byteenable      (byteenable),
		.readdata        (readdata),
		.waitrequest     (waitrequest),
		.capture_in_pin  (capture_in_pin),
		.compare_out_pin (compare_out_pin),
		.compare_pin_en  (compare_pin_en),
		.timer_irq       (timer_irq)
	);

	always #2.5 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One request, held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d, input logic [15:0] n);
		@(posedge clk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= {24'h0, d};
		if (!wr)
			note_q.push_back(n);
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// A zero mask reads without a note worth comparing
	task automatic rr(input logic [5:0] i, input logic [7:0] e, input logic [7:0] m = 8'hff);
		bus({i, 2'b00}, 1'b0, 8'h00, {m, e});
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		bus({i, 2'b00}, 1'b1, d, 16'h0);
	endtask

	// Oldest note is taken off as each read is answered
	always @(posedge clk)
		if (read === 1'b1 && waitrequest === 1'b0 && note_q.size() > 0)
		begin
			note = note_q.pop_front();
			if (note[15:8] != 8'h00)
				check("readdata", readdata[7:0] & note[15:8], note[7:0] & note[15:8]);
		end

	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#20000;
		fails++;
		$display("watchdog expired");
		report_and_stop();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// Compare register resets to zero; park it away so no early match sets its flag
		wr(`IDX_CMP_HIGH, 8'h80);
		wr(`IDX_CMP_LOW, 8'h00);
		rr(`IDX_CMP_HIGH, 8'h80);
		// Reset state, before the first wrap
		rr(`IDX_STATUS, 8'h00);
		rr(`IDX_CONTROL, `CTL_RESET);
		rr(`IDX_PIN_CFG, `PIN_CFG_RESET);
		bus(8'hfc, 1'b0, 8'h00, 16'hff00);
		bus(8'h4d, 1'b0, 8'h00, 16'hff00);
		check("irq", {7'h0, timer_irq}, 8'h00);
		seed = lfsr(seed);
		wr(`IDX_CONTROL, seed[7:0] & 8'he3);
		rr(`IDX_CONTROL, seed[7:0] & 8'he3);
		wr(`IDX_CONTROL, 8'h00);
		$display("test reset done");
		// Overflow: unarmed low read keeps flag, view b never clears it
		repeat (40) @(posedge clk);
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		rr(`IDX_STATUS, 8'h20);
		rr(`IDX_VIEWB_LOW, 8'h00, 8'h00);
		rr(`IDX_STATUS, 8'h20);
		wr(`IDX_CONTROL, 8'h20);
		repeat (2) @(posedge clk);
		#1 check("irq", {7'h0, timer_irq}, 8'h01);
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		rr(`IDX_STATUS, 8'h00);
		repeat (2) @(posedge clk);
		#1 check("irq", {7'h0, timer_irq}, 8'h00);
		wr(`IDX_CONTROL, 8'h00);
		$display("test overflow done");
		// Buffered low byte stays frozen across high reads
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		cnt[7:0] = rd;
		rr(`IDX_CNT_HIGH, 8'h00, 8'h00);
		repeat (40) @(posedge clk);
		rr(`IDX_CNT_HIGH, 8'h00, 8'h00);
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		check("frozen low", {7'h0, (rd - cnt[7:0]) <= 8'd1}, 8'h01);
		// Buffer is released, so this read gives the live count to measure from
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		cnt[7:0] = rd;
		repeat (40) @(posedge clk);
		rr(`IDX_VIEWB_LOW, 8'h00, 8'h00);
		check("live low", {7'h0, (rd - cnt[7:0]) inside {[8'd9:8'd12]}}, 8'h01);
		$display("test counter done");
		// Capture: falling selected, rising ignored
		wr(`IDX_CONTROL, 8'h80);
		capture_in_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rr(`IDX_STATUS, 8'h00);
		capture_in_pin <= 1'b0;
		repeat (10) @(posedge clk);
		#1 check("irq", {7'h0, timer_irq}, 8'h01);
		rr(`IDX_STATUS, 8'h80);
		rr(`IDX_CAP_LOW, 8'h00, 8'h00);
		rr(`IDX_STATUS, 8'h00);
		wr(`IDX_CONTROL, 8'h02);
		rr(`IDX_CNT_LOW, 8'h00, 8'h00);
		cnt[7:0] = rd;
		capture_in_pin <= 1'b1;
		repeat (10) @(posedge clk);
		#1 check("irq", {7'h0, timer_irq}, 8'h00);
		rr(`IDX_CAP_LOW, 8'h00, 8'h00);
		check("captured", {7'h0, (rd - cnt[7:0]) <= 8'd4}, 8'h01);
		rr(`IDX_STATUS, 8'h80);
		rr(`IDX_CAP_LOW, 8'h00, 8'h00);
		cnt[7:0] = rd;
		// High read freezes the capture register until its low byte is read
		rr(`IDX_CAP_HIGH, 8'h00, 8'h00);
		capture_in_pin <= 1'b0;
		repeat (10) @(posedge clk);
		capture_in_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rr(`IDX_STATUS, 8'h00);
		rr(`IDX_CAP_LOW, cnt[7:0]);
		$display("test capture done");
		// Compare with both output levels, pin routed to the timer
		wr(`IDX_PIN_CFG, 8'h01);
		#1 check("pin enable", {7'h0, compare_pin_en}, 8'h01);
		for (int l = 1; l >= 0; l--)
		begin
			wr(`IDX_CONTROL, {7'h0, l[0]});
			rr(`IDX_CNT_HIGH, 8'h00, 8'h00);
			cnt[15:8] = rd;
			rr(`IDX_CNT_LOW, 8'h00, 8'h00);
			cnt[7:0] = rd;
			seed = lfsr(seed);
			cnt = cnt + 16'd16 + {13'h0, seed[2:0]};
			wr(`IDX_CMP_HIGH, cnt[15:8]);
			wr(`IDX_CMP_LOW, cnt[7:0]);
			rr(`IDX_STATUS, 8'h00);
			repeat (120) @(posedge clk);
			rr(`IDX_STATUS, 8'h40);
			check("compare pin", {7'h0, compare_out_pin}, {7'h0, l[0]});
			wr(`IDX_CMP_LOW, cnt[7:0]);
			rr(`IDX_STATUS, 8'h00);
		end
		wr(`IDX_PIN_CFG, 8'h00);
		#1 check("pin enable", {7'h0, compare_pin_en}, 8'h00);
		$display("test compare done");
		report_and_stop();
	end
endmodule
